// ==== common/vintc_params.svh ====
// register offsets, field positions and reset values of the vector interrupt unit
// assumes 12-bit byte offsets within the unit's window on an APB bus
`ifndef VINTC_PARAMS_SVH
`define VINTC_PARAMS_SVH

// word registers, byte offsets
`define VINTC_OFF_NORM_STAT  12'h000
`define VINTC_OFF_FAST_STAT  12'h004
`define VINTC_OFF_RAW_STAT   12'h008
`define VINTC_OFF_CLASS_SEL  12'h00C
`define VINTC_OFF_EN_SET     12'h010
`define VINTC_OFF_EN_CLR     12'h014
`define VINTC_OFF_SOFT_SET   12'h018
`define VINTC_OFF_SOFT_CLR   12'h01C
`define VINTC_OFF_PROTECT    12'h020
`define VINTC_OFF_VEC_ADDR   12'h030
`define VINTC_OFF_DEF_ADDR   12'h034
`define VINTC_OFF_EVT_STAT   12'h040
`define VINTC_OFF_EVT_MASK   12'h044

// slot pages, offset bits 11:8; slot n at page base + 4n
`define VINTC_PAGE_SLOT_ADDR 4'h1
`define VINTC_PAGE_SLOT_CTL  4'h2

// field positions
`define VINTC_SLOT_SRC_LSB   0
`define VINTC_SLOT_EN_BIT    5
`define VINTC_PROT_BIT       0
`define VINTC_EVT_PROT_BIT   0
`define VINTC_EVT_SIZE_BIT   1

// reset values and bus constants
`define VINTC_RST_WORD       32'h0000_0000
`define VINTC_RST_EVT        2'h0
`define VINTC_FULL_STRB      4'hF

`endif

// ==== common/vintc_pkg.sv ====
// types shared by the vector interrupt unit modules
// assumes nothing beyond a SystemVerilog compiler
package vintc_pkg;

   // width of a source index
   localparam int SRC_W = 5;

   // apb request fields that travel together
   typedef struct packed {
      logic [11:0] paddr;
      logic        pwrite;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
      logic [2:0]  pprot;
   } vintc_apb_req_t;

   // one vectored slot's control
   typedef struct packed {
      logic             en;
      logic [SRC_W-1:0] src;
   } vintc_slot_cfg_t;

endpackage

// ==== rtl/vintc_slot.sv ====
// one vectored slot: compares its chosen source against the normal requests
// assumes the requests are already enabled and classed as normal
`timescale 1ns/1ps
`default_nettype none

module vintc_slot #(
   parameter int NSRC = 32
) (
   // slot control
   input  wire vintc_pkg::vintc_slot_cfg_t cfg,
   // enabled normal requests
   input  wire logic [NSRC-1:0]            norm_req,
   // slot is requesting
   output logic                            hit
);

   // any source may sit in any slot
   assign hit = cfg.en & norm_req[cfg.src]; // R4

endmodule

`default_nettype wire

// ==== rtl/vintc_prio.sv ====
// slot priority chooser: lowest requesting slot wins, else default address
// assumes hit bits come from the slot comparators of the same cycle
`timescale 1ns/1ps
`default_nettype none

module vintc_prio #(
   parameter int NSLOT = 16
) (
   // slot state
   input  wire logic [NSLOT-1:0]       hit,
   input  wire logic [NSLOT-1:0][31:0] slot_addr,
   input  wire logic [31:0]            def_addr,
   // chosen address
   output logic [31:0]                 vec_addr,
   output logic                        any_hit
);

   // scan from lowest priority up so slot 0 overrides all
   always_comb begin
      vec_addr = def_addr; // R8
      for (int i = NSLOT - 1; i >= 0; i--) begin
         if (hit[i]) begin
            vec_addr = slot_addr[i]; // R7
         end
      end
   end

   // any vectored slot requesting
   assign any_hit = |hit;

endmodule

`default_nettype wire

// ==== rtl/vintc_top.sv ====
// vector interrupt unit: classes 32 requests into fast, vectored, default
// assumes an APB master on mclk and requests synchronous to mclk
//
// Behaviour
// R1: 32 request inputs, each classed by software as fast, vectored or default.
// R2: fast interrupt output is the OR of all fast-classed enabled requests.
// R3: a readable word shows which fast-classed sources are requesting.
// R4: 16 vectored slots take any source; slot 0 highest, 15 lowest.
// R5: fixed ranking: fast first, then vectored, then default normal requests.
// R6: normal interrupt output is the OR of all enabled normal-classed requests.
// R7: vector address read returns highest-priority requesting slot's routine address.
// R8: with no slot requesting, vector address read returns the default address.
// R9: a readable word shows which normal requests are active.
// R10: software uses full-word accesses only; partial writes are not supported.
// R11: software interrupt bits are ORed with the hardware requests.
// R12: ones written to enable-clear clear enables; zeros leave them.
// R13: class status shows enabled requests of that class; raw shows all.
// R14: with protection on, only privileged accesses are accepted.
// R15: both interrupt outputs are levels held while qualifying requests remain.
// R16: enabled normal request in no slot counts only as default path.
`timescale 1ns/1ps
`default_nettype none
`include "vintc_params.svh"

module vintc_top #(
   parameter int NSLOT = 16
) (
   // clock, reset, enable
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire vintc_pkg::vintc_apb_req_t apb_req,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   // peripheral requests
   input  wire logic [31:0]               irq_in,
   // to the processor core
   output logic                           fast_interrupt,
   output logic                           norm_interrupt,
   // bus fault interrupt
   output logic                           fault_irq
);

   localparam int NSRC = 32;
   localparam int SW   = vintc_pkg::SRC_W;

   // software state
   logic [NSRC-1:0]                         sel_q;
   logic [NSRC-1:0]                         en_q;
   logic [NSRC-1:0]                         soft_q;
   logic                                    prot_q;
   logic [31:0]                             def_q;
   logic [NSLOT-1:0][31:0]                  slot_addr_q;
   vintc_pkg::vintc_slot_cfg_t [NSLOT-1:0]  slot_cfg_q;
   logic [1:0]                              evt_q;
   logic [1:0]                              mask_q;
   // bus state
   logic                                    rdy_q;
   logic                                    err_q;
   logic [31:0]                             rdata_q;
   logic [31:0]                             rdata_d;
   logic                                    err_d;
   // output state
   logic                                    fast_q;
   logic                                    norm_q;
   logic                                    fault_q;
   // request paths
   logic [NSRC-1:0]                         raw_w;
   logic [NSRC-1:0]                         fast_stat_w;
   logic [NSRC-1:0]                         norm_stat_w;
   logic [NSLOT-1:0]                        hit_w;
   logic [31:0]                             vec_w;
   logic                                    any_hit_w;
   // bus decode
   logic [11:0]                             addr;
   logic [31:0]                             wdata;
   logic [3:0]                              sidx;
   logic                                    cap_w;
   logic                                    acc_w;
   logic                                    priv_ok;
   logic                                    size_ok;
   logic                                    slot_ok;
   logic                                    apg_w;
   logic                                    cpg_w;
   logic                                    map_w;
   logic                                    wr_ok_w;
   logic [1:0]                              evt_set_w;
   logic [1:0]                              evt_clr_w;

   // request classing
   assign raw_w       = irq_in | soft_q;          // R11 R1
   assign fast_stat_w = raw_w & en_q & sel_q;     // R13 R3
   assign norm_stat_w = raw_w & en_q & ~sel_q;    // R13 R9 R16

   // vectored slots see only normal requests, so fast ranks above them
   genvar g;
   generate
      for (g = 0; g < NSLOT; g++) begin : g_slot
         vintc_slot #(
            .NSRC     (NSRC)
         ) u_slot (
            .cfg      (slot_cfg_q[g]),
            .norm_req (norm_stat_w),
            .hit      (hit_w[g])
         ); // R5
      end
   endgenerate

   // slot priority and default address
   vintc_prio #(
      .NSLOT     (NSLOT)
   ) u_prio (
      .hit       (hit_w),
      .slot_addr (slot_addr_q),
      .def_addr  (def_q),
      .vec_addr  (vec_w),
      .any_hit   (any_hit_w)
   );

   // bus fields and phases
   assign addr    = apb_req.paddr;
   assign wdata   = apb_req.pwdata;
   assign sidx    = addr[5:2];
   assign cap_w   = ce & psel & ~rdy_q;
   assign acc_w   = ce & psel & penable & rdy_q;
   assign priv_ok = ~prot_q | apb_req.pprot[0];                    // R14
   assign size_ok = ~apb_req.pwrite | (apb_req.pstrb == `VINTC_FULL_STRB); // R10
   assign slot_ok = ({28'h0000000, sidx} < NSLOT) & (addr[7:6] == 2'h0);
   assign apg_w   = (addr[11:8] == `VINTC_PAGE_SLOT_ADDR) & slot_ok;
   assign cpg_w   = (addr[11:8] == `VINTC_PAGE_SLOT_CTL) & slot_ok;
   assign wr_ok_w = acc_w & apb_req.pwrite & map_w & priv_ok & size_ok;

   // answer: data latched in setup, ready one cycle later
   assign pready  = psel & penable & rdy_q & ce;
   assign pslverr = pready & err_q;
   assign prdata  = rdata_q;

   // read mux and address map
   always_comb begin
      rdata_d = `VINTC_RST_WORD;
      map_w   = 1'b1;
      if (apg_w) begin
         rdata_d = slot_addr_q[sidx];
      end else if (cpg_w) begin
         rdata_d[`VINTC_SLOT_EN_BIT] = slot_cfg_q[sidx].en;
         rdata_d[`VINTC_SLOT_SRC_LSB +: SW] = slot_cfg_q[sidx].src;
      end else begin
         case (addr)
            `VINTC_OFF_NORM_STAT: rdata_d = norm_stat_w;     // R9
            `VINTC_OFF_FAST_STAT: rdata_d = fast_stat_w;     // R3
            `VINTC_OFF_RAW_STAT:  rdata_d = raw_w;           // R13
            `VINTC_OFF_CLASS_SEL: rdata_d = sel_q;
            `VINTC_OFF_EN_SET:    rdata_d = en_q;
            `VINTC_OFF_EN_CLR:    rdata_d = `VINTC_RST_WORD;
            `VINTC_OFF_SOFT_SET:  rdata_d = soft_q;
            `VINTC_OFF_SOFT_CLR:  rdata_d = `VINTC_RST_WORD;
            `VINTC_OFF_PROTECT:   rdata_d[`VINTC_PROT_BIT] = prot_q;
            `VINTC_OFF_VEC_ADDR:  rdata_d = vec_w;           // R7 R8
            `VINTC_OFF_DEF_ADDR:  rdata_d = def_q;
            `VINTC_OFF_EVT_STAT:  rdata_d[1:0] = evt_q;
            `VINTC_OFF_EVT_MASK:  rdata_d[1:0] = mask_q;
            default:              map_w = 1'b0;
         endcase
      end
      // refused accesses read as zero
      if (!priv_ok || !map_w) begin
         rdata_d = `VINTC_RST_WORD; // R14
      end
      err_d = ~map_w | ~priv_ok | ~size_ok;
   end

   // setup capture and access completion
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdy_q   <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= `VINTC_RST_WORD;
      end else if (cap_w) begin
         rdy_q   <= 1'b1;
         err_q   <= err_d;
         rdata_q <= apb_req.pwrite ? `VINTC_RST_WORD : rdata_d;
      end else if (acc_w) begin
         rdy_q   <= 1'b0;
      end
   end

   // class select: one means fast
   always_ff @(posedge mclk) begin
      if (rst) begin
         sel_q <= `VINTC_RST_WORD;
      end else if (wr_ok_w && addr == `VINTC_OFF_CLASS_SEL) begin
         sel_q <= wdata; // R1
      end
   end

   // enables: set by ones, cleared by ones at the clear location
   always_ff @(posedge mclk) begin
      if (rst) begin
         en_q <= `VINTC_RST_WORD;
      end else if (wr_ok_w && addr == `VINTC_OFF_EN_SET) begin
         en_q <= en_q | wdata;
      end else if (wr_ok_w && addr == `VINTC_OFF_EN_CLR) begin
         en_q <= en_q & ~wdata; // R12
      end
   end

   // software interrupts: set and clear by ones
   always_ff @(posedge mclk) begin
      if (rst) begin
         soft_q <= `VINTC_RST_WORD;
      end else if (wr_ok_w && addr == `VINTC_OFF_SOFT_SET) begin
         soft_q <= soft_q | wdata; // R11
      end else if (wr_ok_w && addr == `VINTC_OFF_SOFT_CLR) begin
         soft_q <= soft_q & ~wdata;
      end
   end

   // protection and default address
   always_ff @(posedge mclk) begin
      if (rst) begin
         prot_q <= 1'b0;
         def_q  <= `VINTC_RST_WORD;
      end else begin
         if (wr_ok_w && addr == `VINTC_OFF_PROTECT) begin
            prot_q <= wdata[`VINTC_PROT_BIT]; // R14
         end
         if (wr_ok_w && addr == `VINTC_OFF_DEF_ADDR) begin
            def_q <= wdata; // R8
         end
      end
   end

   // slot routine addresses
   always_ff @(posedge mclk) begin
      if (rst) begin
         slot_addr_q <= '0;
      end else if (wr_ok_w && apg_w) begin
         slot_addr_q[sidx] <= wdata; // R7
      end
   end

   // slot control: enable and source index
   always_ff @(posedge mclk) begin
      if (rst) begin
         slot_cfg_q <= '0;
      end else if (wr_ok_w && cpg_w) begin
         slot_cfg_q[sidx].en  <= wdata[`VINTC_SLOT_EN_BIT]; // R4
         slot_cfg_q[sidx].src <= wdata[`VINTC_SLOT_SRC_LSB +: SW];
      end
   end

   // fault events: refused privilege, partial-width write
   assign evt_set_w[`VINTC_EVT_PROT_BIT] = acc_w & ~priv_ok; // R14
   assign evt_set_w[`VINTC_EVT_SIZE_BIT] = acc_w & priv_ok & ~size_ok; // R10
   assign evt_clr_w = (wr_ok_w && addr == `VINTC_OFF_EVT_STAT) ? wdata[1:0] : 2'h0;

   // sticky status, set wins over clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         evt_q <= `VINTC_RST_EVT;
      end else if (ce) begin
         evt_q <= (evt_q & ~evt_clr_w) | evt_set_w;
      end
   end

   // fault mask
   always_ff @(posedge mclk) begin
      if (rst) begin
         mask_q <= `VINTC_RST_EVT;
      end else if (wr_ok_w && addr == `VINTC_OFF_EVT_MASK) begin
         mask_q <= wdata[1:0];
      end
   end

   // level outputs to the core
   always_ff @(posedge mclk) begin
      if (rst) begin
         fast_q  <= 1'b0;
         norm_q  <= 1'b0;
         fault_q <= 1'b0;
      end else if (ce) begin
         fast_q  <= |fast_stat_w; // R2 R15
         norm_q  <= |norm_stat_w; // R6 R15
         fault_q <= |(evt_q & mask_q);
      end
   end

   assign fast_interrupt = fast_q;
   assign norm_interrupt = norm_q;
   assign fault_irq      = fault_q;

   // checks on the design's own signals
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // accepted write completing at a given offset
   sequence s_wr(logic [11:0] off);
      wr_ok_w && addr == off;
   endsequence

   // read setup at a given offset, privileged
   sequence s_rd(logic [11:0] off);
      cap_w && !apb_req.pwrite && addr == off && priv_ok;
   endsequence

   // access phase that protection refuses
   sequence s_unpriv;
      pready && prot_q && !apb_req.pprot[0];
   endsequence

   a_fast_level: assert property (ce |=> fast_interrupt == $past(|fast_stat_w)) // R2
      else $error("fast output does not follow fast requests");
   a_norm_level: assert property (ce |=> norm_interrupt == $past(|norm_stat_w)) // R6
      else $error("normal output does not follow normal requests");
   a_level_hold: assert property (ce && fast_interrupt && (|fast_stat_w) |=> fast_interrupt) // R15
      else $error("fast output dropped while request active");
   a_class_split: assert property ((fast_stat_w & norm_stat_w) == 32'h0000_0000) // R5
      else $error("request counted in two classes");
   // a fast-classed source must never win the top slot
   a_fast_noslot: assert property (hit_w[0] |-> !sel_q[slot_cfg_q[0].src]) // R5
      else $error("fast source raised a vectored slot");
   a_enclr_bits: assert property (s_wr(`VINTC_OFF_EN_CLR) |=>
      en_q == ($past(en_q) & ~$past(wdata))) // R12
      else $error("enable clear wrong");
   a_soft_raise: assert property (s_wr(`VINTC_OFF_SOFT_SET) |=>
      (raw_w & $past(wdata)) == $past(wdata)) // R11
      else $error("software bit did not raise request");
   a_prot_reject: assert property (s_unpriv |-> pslverr ##1 ($stable(en_q) && $stable(sel_q))) // R14
      else $error("unprivileged access not refused");
   a_vec_default: assert property (s_rd(`VINTC_OFF_VEC_ADDR) ##0 !any_hit_w |=>
      prdata == $past(def_q)) // R8
      else $error("default address not returned");
   a_vec_slot0: assert property (s_rd(`VINTC_OFF_VEC_ADDR) ##0 hit_w[0] |=>
      prdata == $past(slot_addr_q[0])) // R7
      else $error("slot 0 address not returned");
   a_fast_word: assert property (s_rd(`VINTC_OFF_FAST_STAT) |=>
      prdata == $past(fast_stat_w)) // R3
      else $error("fast status word wrong");
   a_size_event: assert property (pready && priv_ok && !size_ok |=>
      evt_q[`VINTC_EVT_SIZE_BIT]) // R10
      else $error("partial write not flagged");

endmodule

`default_nettype wire

// ==== tb/vintc_core_model.sv ====
// processor core stand-in: watches the two interrupt levels and counts entries
// assumes both levels are registered on mclk by the interrupt unit
`timescale 1ns/1ps
`default_nettype none

module vintc_core_model (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // interrupt levels from the unit
   input  wire logic       fast_interrupt,
   input  wire logic       norm_interrupt,
   // service entries seen so far
   output logic [7:0]      fast_entries,
   output logic [7:0]      norm_entries
);
   logic in_fast_q;
   logic in_norm_q;

   // fast entry wins; a normal entry is taken only with no fast level pending
   always_ff @(posedge mclk) begin
      if (rst) begin
         in_fast_q    <= 1'b0;
         in_norm_q    <= 1'b0;
         fast_entries <= 8'h00;
         norm_entries <= 8'h00;
      end else begin
         in_fast_q <= fast_interrupt;
         in_norm_q <= norm_interrupt & ~fast_interrupt;
         if (fast_interrupt && !in_fast_q) begin
            fast_entries <= fast_entries + 8'h01;
         end
         if (norm_interrupt && !fast_interrupt && !in_norm_q) begin
            norm_entries <= norm_entries + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

// ==== tb/vintc_bench.sv ====
// self-checking bench of the vector interrupt unit over APB
// assumes zero-wait APB answers and one-cycle interrupt output latency
`timescale 1ns/1ps
`default_nettype none
`include "vintc_params.svh"

module vintc_bench;
   logic                      mclk, rst, ce, psel, penable;
   vintc_pkg::vintc_apb_req_t apb_req;
   logic [31:0]               prdata, irq_in, rd;
   logic                      pready, pslverr, fast_interrupt, norm_interrupt, fault_irq, er;
   logic [7:0]                fast_entries, norm_entries;
   int                        errors, cmp_count;

   vintc_top #(.NSLOT(16)) uut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .apb_req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_in(irq_in), .fast_interrupt(fast_interrupt),
      .norm_interrupt(norm_interrupt), .fault_irq(fault_irq));

   vintc_core_model core (.mclk(mclk), .rst(rst), .fast_interrupt(fast_interrupt),
      .norm_interrupt(norm_interrupt), .fast_entries(fast_entries),
      .norm_entries(norm_entries));

   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one transfer with the given strobes and protection; entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] st, input logic [2:0] pr);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      apb_req <= '{paddr: a, pwrite: wr, pwdata: d, pstrb: st, pprot: pr};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next call never re-drives psel in this time step
      @(posedge mclk);
      if (n >= 20) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         wrap_up();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, `VINTC_FULL_STRB, 3'h1);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, `VINTC_FULL_STRB, 3'h1);
      chk(rd, exp);
   endtask

   // outputs sampled two edges after the requests change
   task automatic outs(input logic [2:0] exp);
      @(posedge mclk);
      @(posedge mclk);
      chk({29'h0, fault_irq, fast_interrupt, norm_interrupt}, {29'h0, exp});
   endtask

   task automatic t_reset();
      rdc(`VINTC_OFF_CLASS_SEL, 32'h0);
      rdc(`VINTC_OFF_EN_SET, 32'h0);
      rdc(`VINTC_OFF_PROTECT, 32'h0);
      rdc(12'h100, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_fast();
      wr(`VINTC_OFF_CLASS_SEL, 32'h0000_0008);
      wr(`VINTC_OFF_EN_SET, 32'h0000_0008);
      irq_in <= 32'h0000_0008;
      outs(3'h2);
      @(posedge mclk);
      chk({24'h0, fast_entries}, 32'h1);
      rdc(`VINTC_OFF_FAST_STAT, 32'h0000_0008);
      rdc(`VINTC_OFF_NORM_STAT, 32'h0);
      ce     <= 1'b0;
      irq_in <= 32'h0;
      outs(3'h2);
      ce     <= 1'b1;
      outs(3'h0);
      $display("test fast done");
   endtask

   task automatic t_vec();
      wr(`VINTC_OFF_EN_SET, 32'h0000_0290);
      wr(12'h208, 32'h0000_0027);
      wr(12'h214, 32'h0000_0024);
      wr(12'h108, 32'h0000_2200);
      wr(12'h114, 32'h0000_5500);
      wr(`VINTC_OFF_DEF_ADDR, 32'h0000_DEF0);
      irq_in <= 32'h0000_0010;
      outs(3'h1);
      rdc(`VINTC_OFF_VEC_ADDR, 32'h0000_5500);
      rdc(`VINTC_OFF_NORM_STAT, 32'h0000_0010);
      irq_in <= 32'h0000_0090;
      rdc(`VINTC_OFF_VEC_ADDR, 32'h0000_2200);
      irq_in <= 32'h0000_0200;
      rdc(`VINTC_OFF_VEC_ADDR, 32'h0000_DEF0);
      chk({31'h0, norm_interrupt}, 32'h1);
      wr(12'h200, 32'h0000_0029);
      wr(12'h100, 32'h0000_0900);
      rdc(`VINTC_OFF_VEC_ADDR, 32'h0000_0900);
      wr(`VINTC_OFF_CLASS_SEL, 32'h0000_0080);
      irq_in <= 32'h0000_0090;
      outs(3'h3);
      rdc(`VINTC_OFF_VEC_ADDR, 32'h0000_5500);
      irq_in <= 32'h0;
      $display("test vectored done");
   endtask

   task automatic t_soft();
      wr(`VINTC_OFF_EN_CLR, 32'hFFFF_FFFF);
      wr(`VINTC_OFF_EN_SET, 32'h0000_10F0);
      wr(`VINTC_OFF_EN_CLR, 32'h0000_0030);
      rdc(`VINTC_OFF_EN_SET, 32'h0000_10C0);
      wr(`VINTC_OFF_SOFT_SET, 32'h0000_1000);
      rdc(`VINTC_OFF_RAW_STAT, 32'h0000_1000);
      outs(3'h1);
      wr(`VINTC_OFF_SOFT_CLR, 32'h0000_1000);
      rdc(`VINTC_OFF_RAW_STAT, 32'h0);
      $display("test soft done");
   endtask

   task automatic t_prot();
      apb(1'b0, 12'h050, 32'h0, `VINTC_FULL_STRB, 3'h1);
      chk({31'h0, er}, 32'h1);
      wr(`VINTC_OFF_PROTECT, 32'h1);
      apb(1'b1, `VINTC_OFF_DEF_ADDR, 32'h0000_0BAD, `VINTC_FULL_STRB, 3'h0);
      chk({31'h0, er}, 32'h1);
      rdc(`VINTC_OFF_DEF_ADDR, 32'h0000_DEF0);
      apb(1'b1, `VINTC_OFF_DEF_ADDR, 32'h0000_0BAD, 4'h3, 3'h1);
      chk({31'h0, er}, 32'h1);
      rdc(`VINTC_OFF_EVT_STAT, 32'h3);
      outs(3'h0);
      wr(`VINTC_OFF_EVT_MASK, 32'h1);
      outs(3'h4);
      wr(`VINTC_OFF_EVT_STAT, 32'h3);
      outs(3'h0);
      wr(`VINTC_OFF_PROTECT, 32'h0);
      $display("test protection done");
   endtask

   // main sequence
   initial begin
      errors    = 0;
      cmp_count = 0;
      rst       = 1'b1;
      ce        = 1'b1;
      psel      = 1'b0;
      penable   = 1'b0;
      apb_req   = '0;
      irq_in    = 32'h0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_fast();
      t_vec();
      t_soft();
      t_prot();
      wrap_up();
   end
endmodule

`default_nettype wire
